// >>> inc/lcdsd_regs.vh
`ifndef LCDSD_REGS_VH
`define LCDSD_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define LCDSD_ADDR_CTRL   8'h00
`define LCDSD_ADDR_DIVL   8'h01
`define LCDSD_ADDR_DIVH   8'h02
`define LCDSD_ADDR_TOGR   8'h03
`define LCDSD_ADDR_MEM0   8'h10

// ----------------------------------------------------------------------------
// Control fields and resets
// ----------------------------------------------------------------------------
`define LCDSD_BIT_BIAS    0
`define LCDSD_BIT_MUXLO   1
`define LCDSD_BIT_MUXHI   2
`define LCDSD_BIT_SIZE    3
`define LCDSD_BIT_BLANK   4
`define LCDSD_CTRL_MASK   8'h1F
`define LCDSD_CTRL_RESET  8'h00
`define LCDSD_MUX_STATIC  2'h0
`define LCDSD_MUX_TWO     2'h1
`define LCDSD_MUX_THREE   2'h2
`define LCDSD_MUX_FOUR    2'h3
`define LCDSD_MEM_WORDS   16

`endif

// >>> rtl/lcdsd_driver.v
`timescale 1ns/1ps
`include "lcdsd_regs.vh"

module lcdsd_driver #(
  parameter NUM_SEG  = 32,
  parameter DIV_W    = 10
) (
  // System
  input  wire              clock,
  input  wire              rst,
  // Timing source
  input  wire              osc_tick,
  input  wire              ext_clk_tick,
  input  wire              clk_src_ext,
  // Register port
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  // Master enable
  input  wire              display_en,
  // Drive levels: 0..3 in thirds (one-third bias) or 0,1/2 as 0..2 halves
  output reg  [4*2-1:0]    com_level,
  output reg  [NUM_SEG*2-1:0] seg_level,
  output reg  [NUM_SEG-1:0]   seg_en,
  output reg               bias_half,
  output reg               frame_phase
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]       ctrl_q;
  reg  [DIV_W-1:0] div_q;
  reg  [7:0]       togr_q;
  reg  [7:0]       mem_q [0:`LCDSD_MEM_WORDS-1];

  wire [1:0] mux_select = ctrl_q[`LCDSD_BIT_MUXHI:`LCDSD_BIT_MUXLO];
  wire       blank      = ctrl_q[`LCDSD_BIT_BLANK];
  wire       wide       = ctrl_q[`LCDSD_BIT_SIZE];
  wire [2:0] mux_count  = {1'b0, mux_select} + 3'h1;
  // The memory decode covers one aligned block of addresses, so the low
  // address bits index the word directly.
  wire       mem_hit    = (reg_addr >= `LCDSD_ADDR_MEM0) &&
                          (reg_addr <  `LCDSD_ADDR_MEM0 + `LCDSD_MEM_WORDS);
  wire [3:0] mem_idx    = reg_addr[3:0];

  // Writes land on the edge that samples reg_wr, so a read issued on the
  // next cycle already returns the new value. Reserved control bits are
  // masked on the way in rather than on the way out, which keeps the stored
  // copy and the read-back identical.
  integer i;
  always @(posedge clock) begin
    if (rst) begin
      ctrl_q <= `LCDSD_CTRL_RESET;
      div_q  <= {DIV_W{1'b0}};
      togr_q <= 8'h00;
      for (i = 0; i < `LCDSD_MEM_WORDS; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `LCDSD_ADDR_CTRL: ctrl_q <= reg_wdata & `LCDSD_CTRL_MASK;
        `LCDSD_ADDR_DIVL: div_q[7:0] <= reg_wdata;
        `LCDSD_ADDR_DIVH: div_q[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
        `LCDSD_ADDR_TOGR: togr_q <= {4'h0, reg_wdata[3:0]};
        default: begin
          if (mem_hit) begin
            mem_q[mem_idx] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // Read data is registered and held until the next read, so the host may
  // take it at leisure; unmapped addresses answer with zero.
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `LCDSD_ADDR_CTRL: reg_rdata <= ctrl_q;
        `LCDSD_ADDR_DIVL: reg_rdata <= div_q[7:0];
        `LCDSD_ADDR_DIVH: reg_rdata <= {{(16-DIV_W){1'b0}}, div_q[DIV_W-1:8]};
        `LCDSD_ADDR_TOGR: reg_rdata <= togr_q;
        default:          reg_rdata <= mem_hit ? mem_q[mem_idx] : 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Timing: source halved, then prescaled into common slots
  // --------------------------------------------------------------------------
  // Each frame has 2 polarities x mux_count slots, and each slot lasts (div+1)
  // ticks of the halved clock, that is 2 * (div+1) source ticks, so
  // refresh = f / (4 * mux * (div+1)).
  wire src_tick = clk_src_ext ? ext_clk_tick : osc_tick;
  reg              half_q;
  reg  [DIV_W:0]   pre_q;
  reg  [1:0]       com_q;
  reg  [7:0]       blink_q;
  reg              blink_on_q;
  // Greater-or-equal lets both counters recover at the next slot when
  // software shrinks the divider or the mux count while running; an exact
  // match would leave them running through a full wrap first.
  wire             slot_last = (pre_q >= {1'b0, div_q});
  wire             com_last  = ({1'b0, com_q} + 3'h1 >= mux_count);
  wire             slot_end  = src_tick && half_q && slot_last;
  wire             frame_end = slot_end && com_last && frame_phase;

  // Disabling the display parks every counter, so the first frame after
  // enabling always starts at common 0 with the first polarity.
  always @(posedge clock) begin
    if (rst || !display_en) begin
      half_q      <= 1'b0;
      pre_q       <= {(DIV_W+1){1'b0}};
      com_q       <= 2'h0;
      frame_phase <= 1'b0;
      blink_q     <= 8'h00;
      blink_on_q  <= 1'b1;
    end else if (src_tick) begin
      half_q <= ~half_q;
      if (half_q) begin
        if (slot_last) begin
          pre_q <= {(DIV_W+1){1'b0}};
          if (com_last) begin
            com_q       <= 2'h0;
            frame_phase <= ~frame_phase;
          end else begin
            com_q <= com_q + 2'h1;
          end
        end else begin
          pre_q <= pre_q + {{DIV_W{1'b0}}, 1'b1};
        end
      end
      // Blinking counts whole frames, so the glass always sees a balanced
      // pair of polarities before a segment is hidden or shown again. A
      // toggle rate of zero forces the display visible.
      if (frame_end && togr_q[3:0] != 4'h0) begin
        if (blink_q[3:0] >= togr_q[3:0] - 4'h1) begin
          blink_q    <= 8'h00;
          blink_on_q <= ~blink_on_q;
        end else begin
          blink_q <= blink_q + 8'h01;
        end
      end else if (togr_q[3:0] == 4'h0) begin
        blink_on_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Waveforms
  // --------------------------------------------------------------------------
  // Levels are in units of the bias step: full swing is 3 (one-third) or 2
  // (half). Selected common sits at the rail, the other active ones at the middle
  // levels; segments sit opposite to the common for "on".
  wire [1:0] top    = ctrl_q[`LCDSD_BIT_BIAS] ? 2'h2 : 2'h3;
  wire [1:0] mid_lo = 2'h1;
  wire [1:0] mid_hi = ctrl_q[`LCDSD_BIT_BIAS] ? 2'h1 : 2'h2;
  // Off segments stay at most one bias step from every active common at all times, below
  // the panel's threshold, while on segments see the full swing in their own
  // slot. The price is a one-step field across off segments even in static
  // drive, accepted so that one level table serves every mux mode.
  wire [4*2-1:0]       com_level_d;
  wire [NUM_SEG*2-1:0] seg_level_d;
  wire [NUM_SEG-1:0]   seg_en_d;

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_com
      // Commons beyond the selected count rest at 0 while the segments keep swinging,
      // so a segment wired to them still sees up to the full swing.
      assign com_level_d[c*2 +: 2] = (c > mux_select) ? 2'h0 :
                                     (com_q == c) ? (frame_phase ? 2'h0 : top) :
                                     (frame_phase ? mid_hi : mid_lo);
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < NUM_SEG; s = s + 1) begin : g_seg
      // Memory holds four common bits per segment, two segments per byte.
      wire [7:0] word   = mem_q[s/2];
      wire       bit_on = word[(s%2)*4 + com_q] && !blank && blink_on_q;
      assign seg_en_d[s] = (s < 16) || wide;
      assign seg_level_d[s*2 +: 2] = bit_on ? (frame_phase ? top : 2'h0) :
                                              (frame_phase ? mid_lo : mid_hi);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // Commons and segments update on one edge, so the glass never sees a
  // common and its segments in different phases for a cycle.
  always @(posedge clock) begin
    if (rst || !display_en) begin
      com_level <= {(4*2){1'b0}};
      seg_level <= {(NUM_SEG*2){1'b0}};
      seg_en    <= {NUM_SEG{1'b0}};
    end else begin
      com_level <= com_level_d;
      seg_level <= seg_level_d;
      seg_en    <= seg_en_d;
    end
  end

  // --------------------------------------------------------------------------
  // Bias output
  // --------------------------------------------------------------------------
  // The bias choice is exported for the analog level generator, which sits
  // outside this block and turns the level codes into voltages.
  always @(posedge clock) begin
    if (rst) begin
      bias_half <= 1'b0;
    end else begin
      bias_half <= ctrl_q[`LCDSD_BIT_BIAS];
    end
  end

endmodule // lcdsd_driver

// >>> bench/lcdsd_checker.sv
`timescale 1ns/1ps
module lcdsd_checker #(parameter NUM_SEG = 32) (
  input wire               clock,
  input wire               rst,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [7:0]         reg_addr,
  input wire [7:0]         reg_wdata,
  input wire [7:0]         reg_rdata,
  input wire               display_en,
  input wire [7:0]         com_level,
  input wire [NUM_SEG-1:0] seg_en,
  input wire               bias_half
);
  // Shadow of the control fields, rebuilt from the writes seen at the port.
  reg [4:0] ctrl_q;
  always @(posedge clock) begin
    if (rst) ctrl_q <= 5'h00;
    else if (reg_wr && reg_addr == 8'h00) ctrl_q <= reg_wdata[4:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_steady;
    (display_en && !reg_wr) [*2];
  endsequence
  property p_bias;
    bit b;
    (display_en && reg_wr && reg_addr == 8'h00, b = reg_wdata[0]) ##1 s_steady |-> bias_half == b;
  endproperty
  a_reset_clears: assert property (disable iff (1'b0) rst |=> com_level == 8'h00 && seg_en == 0)
    else $error("outputs not cleared by reset");
  a_ctrl_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h00 |=> reg_rdata == {3'h0, $past(ctrl_q)})
    else $error("control read back wrong");
  a_unmapped_read: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_bias_copy: assert property (p_bias)
    else $error("bias output does not follow control");
  a_narrow_pins: assert property ((display_en && !ctrl_q[3]) [*3] |-> seg_en[NUM_SEG-1:16] == 0)
    else $error("upper pins active in narrow size");
  a_wide_pins: assert property ((display_en && ctrl_q[3]) [*3] |-> &seg_en)
    else $error("pins idle in wide size");
  a_static_com: assert property ((display_en && ctrl_q[2:1] == 2'h0) [*3] |-> com_level[7:2] == 6'h00)
    else $error("unused commons driven in static mode");
  a_half_levels: assert property ((display_en && ctrl_q[0]) [*3] |-> com_level[1:0] != 2'h3)
    else $error("third level used in half bias");
endmodule // lcdsd_checker
bind lcdsd_driver lcdsd_checker #(.NUM_SEG(NUM_SEG)) i_chk (.*);

// >>> bench/lcdsd_panel.sv
`timescale 1ns/1ps
module lcdsd_panel (
  input wire        clock,
  input wire [7:0]  com_level,
  input wire [63:0] seg_level,
  output reg        lit0
);
  // Segment 0 on common 0 shows only when its plates sit more than one bias step apart;
  // the one-step field on an off segment stays below threshold. Valid as a static view only.
  wire [1:0] diff = (seg_level[1:0] > com_level[1:0]) ? seg_level[1:0] - com_level[1:0]
                                                       : com_level[1:0] - seg_level[1:0];
  always @(posedge clock) lit0 <= diff > 2'h1;
endmodule // lcdsd_panel

// >>> bench/test_lcd_segment_driver.sv
`timescale 1ns/1ps
`include "lcdsd_regs.vh"
module test_lcd_segment_driver;
  reg        clock = 1'b0, rst = 1'b1, osc_tick = 1'b0, ext_clk_tick = 1'b0, clk_src_ext = 1'b0;
  reg        reg_wr = 1'b0, reg_rd = 1'b0, display_en = 1'b0;
  reg [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, seen;
  reg [3:0]  tc = 4'h0;
  reg [23:0] rows [0:7];
  wire [7:0] reg_rdata, com_level;
  wire [63:0] seg_level;
  wire [31:0] seg_en;
  wire       bias_half, frame_phase, lit0;
  integer    n_fail = 0, comparisons = 0, i, k, span;
  lcdsd_driver i_dut (.*);
  lcdsd_panel i_panel (.*);
  initial forever #25 clock = ~clock;
  // Oscillator ticks every 4 cycles, external ticks every 16, so the sources are told apart.
  always @(posedge clock) begin
    tc <= tc + 4'h1;
    osc_tick <= tc[1:0] == 2'h3;
    ext_clk_tick <= tc == 4'hF;
  end
  task final_report;
    begin
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task check_byte(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check_span(input integer got, input integer exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: span %0d expected %0d", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clock); reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clock); reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clock); reg_rd <= 1'b0;
      @(negedge clock); check_byte(reg_rdata, e);
    end
  endtask
  // The first two toggles after a change only align; the span after them is a full one.
  task measure(input integer exp);
    reg ph;
    integer w;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        @(negedge clock); ph = frame_phase;
        for (w = 0; w < 3000 && frame_phase === ph; w = w + 1) @(negedge clock);
      end
      ph = frame_phase;
      for (span = 0; span < 3000 && frame_phase === ph; span = span + 1) @(negedge clock);
      check_span(span, exp);
    end
  endtask
  task watch(input integer n);
    begin
      seen = 8'h00;
      repeat (n) @(negedge clock) seen = seen + {7'h0, ~lit0};
    end
  endtask
  initial begin
    #1000000; n_fail = n_fail + 1; final_report;
  end
  initial begin
    rows[0] = {`LCDSD_ADDR_CTRL, 16'hFF1F}; rows[1] = {`LCDSD_ADDR_CTRL, 16'hE606};
    rows[2] = {`LCDSD_ADDR_DIVL, 16'h0101}; rows[3] = {`LCDSD_ADDR_DIVH, 16'h0000};
    rows[4] = {`LCDSD_ADDR_TOGR, 16'h0000}; rows[5] = {`LCDSD_ADDR_MEM0, 16'h0101};
    rows[6] = {8'h1F, 16'hA5A5}; rows[7] = {8'h20, 16'h7700};
    repeat (6) @(posedge clock); rst <= 1'b0;
    @(negedge clock) check_byte(com_level, 8'h00);
    rd(`LCDSD_ADDR_CTRL, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      wr(rows[k][23:16], rows[k][15:8]); rd(rows[k][23:16], rows[k][7:0]);
    end
    @(posedge clock) display_en <= 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      wr(`LCDSD_ADDR_CTRL, k * 2); measure(16 * (k + 1));
    end
    @(posedge clock) clk_src_ext <= 1'b1; measure(256);
    @(posedge clock) clk_src_ext <= 1'b0; wr(`LCDSD_ADDR_CTRL, 8'h00);
    watch(40); watch(200); check_byte(seen, 8'h00);
    wr(`LCDSD_ADDR_CTRL, 8'h10); watch(40); watch(200); check_byte(seen, 8'd200);
    wr(`LCDSD_ADDR_CTRL, 8'h00); wr(`LCDSD_ADDR_TOGR, 8'h01);
    watch(240); check_byte({7'h0, seen > 8'd60 && seen < 8'd180}, 8'h01);
    wr(`LCDSD_ADDR_CTRL, 8'h09); repeat (50) @(posedge clock);
    rst <= 1'b1; @(posedge clock); rst <= 1'b0;
    rd(`LCDSD_ADDR_CTRL, 8'h00);
    final_report;
  end
endmodule // test_lcd_segment_driver
